// ---- hdl/port_rate_limit_storm_cfg.sv ----
// Rate limit and broadcast storm configuration bank with Avalon-MM slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module port_rate_limit_storm_cfg
  import rate_storm_pkg::*;
#(
  parameter int ADDR_W     = 10,
  parameter int WINDOW_CYC = STORM_WINDOW_CYC
)
(
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]       i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  // Switch core status
  input  wire low_bits_t               i_low_bits,
  input  wire logic [NUM_PORTS-1:0]    i_link_10m,
  input  wire logic                    i_bcast_pkt,
  // Limiter settings
  output rate_limit_t [NUM_PORTS-1:0]  o_rx_limit,
  output rate_limit_t [NUM_PORTS-1:0]  o_tx_limit,
  output logic                         o_new_bw_en,
  // Storm protection
  output logic                         o_storm_active,
  output logic                         o_storm_drop,
  output logic                         o_storm_window_end
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (ADDR_W < 10)
    begin : g_bad_addr
      $error("address must carry the word index in bits 9:2");
    end
  endgenerate

  // ****************************************************************
  // Reset values and writable bits per word
  // ****************************************************************
  function automatic logic [15:0] reset_of(input int k);
    logic [15:0] v;
    v = RST_ZERO;
    if (8'(k) + IDX_FIRST == IDX_RESERVED_A)
      v = RST_RESERVED_A;
    else if (8'(k) + IDX_FIRST == IDX_RESERVED_C)
      v = RST_RESERVED_C;
    return v;
  endfunction

  function automatic logic [15:0] mask_of(input int k);
    logic [15:0] v;
    v = MASK_ALL;
    if (8'(k) + IDX_FIRST == IDX_LIMIT_ENABLE)
      v = MASK_ENABLE;
    return v;
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [15:0]       cfg_reg [NUM_REGS];
  logic [7:0]        idx;
  logic              hit;
  logic [15:0]       rd_word;
  logic              wr_fire;
  logic [15:0]       lane_mask;
  logic              wait_reg;
  logic [31:0]       rdata_reg;

  assign idx       = i_avs_address[9:2];
  assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wr_fire   = !wait_reg && i_avs_write && hit;

  always_comb
  begin
    hit     = 1'b0;
    rd_word = 16'h0000;
    if (i_avs_address[1:0] != 2'h0)
      hit = 1'b0;
    else if (idx >= IDX_FIRST && idx <= IDX_LAST)
    begin
      hit     = 1'b1;
      rd_word = cfg_reg[4'(idx - IDX_FIRST)];
    end
  end

  // ****************************************************************
  // Bus handshake: one wait cycle, then the answer
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      wait_reg <= 1'b1;
    else if (wait_reg && (i_avs_read || i_avs_write))
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_reg <= 32'h0000_0000;
    else if (wait_reg && i_avs_read)
      rdata_reg <= {16'h0000, rd_word};
    else if (!wait_reg)
      rdata_reg <= 32'h0000_0000;
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata    = rdata_reg;

  // ****************************************************************
  // Register words
  // ****************************************************************
  generate
    for (genvar k = 0; k < NUM_REGS; k++)
    begin : g_word
      localparam logic [15:0] RST  = reset_of(k);
      localparam logic [15:0] MASK = mask_of(k);
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          cfg_reg[k] <= RST;
        else if (wr_fire && (4'(idx - IDX_FIRST) == 4'(k)))
          cfg_reg[k] <= (cfg_reg[k] & ~(lane_mask & MASK))
                      | (i_avs_writedata[15:0] & lane_mask & MASK);
      end
    end
  endgenerate

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  function automatic logic [3:0] slot(input logic [7:0] i);
    return 4'(i - IDX_FIRST);
  endfunction

  logic [15:0] en_word;
  logic [15:0] tx_low_word;
  logic [15:0] rx_mid_word;
  logic [15:0] mid_mix_word;
  logic [15:0] tx_mid_word;
  logic [15:0] rx_top_word;
  logic [15:0] top_mix_word;
  logic [15:0] tx_top_word;
  logic [15:0] storm_word;
  logic [15:0] slow_word;

  assign en_word      = cfg_reg[slot(IDX_LIMIT_ENABLE)];
  assign tx_low_word  = cfg_reg[slot(IDX_TX_LOW_P2_P5)];
  assign rx_mid_word  = cfg_reg[slot(IDX_RX_MID_P0_P3)];
  assign mid_mix_word = cfg_reg[slot(IDX_MID_MIXED)];
  assign tx_mid_word  = cfg_reg[slot(IDX_TX_MID_P2_P5)];
  assign rx_top_word  = cfg_reg[slot(IDX_RX_TOP_P0_P4)];
  assign top_mix_word = cfg_reg[slot(IDX_TOP_MIXED)];
  assign tx_top_word  = cfg_reg[slot(IDX_TX_TOP_P4_P5)];
  assign storm_word   = cfg_reg[slot(IDX_STORM_CTRL)];
  assign slow_word    = cfg_reg[slot(IDX_STORM_SLOW)];

  function automatic logic [RATE_FIELD_W-1:0] tx_field(input int p, input low_bits_t lo);
    logic [RATE_FIELD_W-1:0] f;
    f = '0;
    case (p)
      5: f = {tx_top_word[5:3], tx_mid_word[15:12],
              tx_low_word[15:12]};
      4: f = {tx_top_word[2:0], tx_mid_word[11:8],
              tx_low_word[11:8]};
      3: f = {top_mix_word[14:12], tx_mid_word[7:4],
              tx_low_word[7:4]};
      2: f = {top_mix_word[11:9], tx_mid_word[3:0],
              tx_low_word[3:0]};
      1: f = {top_mix_word[8:6], mid_mix_word[15:12],
              lo.tx_b3_0_p0_p1[1]};
      default: f = {top_mix_word[5:3], mid_mix_word[11:8],
                    lo.tx_b3_0_p0_p1[0]};
    endcase
    return f;
  endfunction

  function automatic logic [RATE_FIELD_W-1:0] rx_field(input int p, input low_bits_t lo);
    logic [6:0] f;
    f = '0;
    case (p)
      5: f = {top_mix_word[2:0], mid_mix_word[7:4]};
      4: f = {rx_top_word[14:12], mid_mix_word[3:0]};
      3: f = {rx_top_word[11:9], rx_mid_word[15:12]};
      2: f = {rx_top_word[8:6], rx_mid_word[11:8]};
      1: f = {rx_top_word[5:3], rx_mid_word[7:4]};
      default: f = {rx_top_word[2:0], rx_mid_word[3:0]};
    endcase
    return {f, lo.rx_b3_0[p]};
  endfunction

  // Position of each limiter enable in the enable word
  function automatic int rx_en_bit(input int p);
    int b;
    b = 0;
    case (p)
      0: b = 0;
      1: b = 2;
      2: b = 4;
      3: b = 6;
      4: b = 7;
      default: b = 8;
    endcase
    return b;
  endfunction

  function automatic int tx_en_bit(input int p);
    int b;
    b = 1;
    case (p)
      0: b = 1;
      1: b = 3;
      2: b = 5;
      3: b = 9;
      4: b = 10;
      default: b = 11;
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Limiter outputs
  // ****************************************************************
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          o_rx_limit[p] <= '0;
          o_tx_limit[p] <= '0;
        end
        else
        begin
          o_rx_limit[p].en   <= en_word[rx_en_bit(p)];
          o_tx_limit[p].en   <= en_word[tx_en_bit(p)];
          o_rx_limit[p].kbps <= {rx_field(p, i_low_bits), 6'h00};
          o_tx_limit[p].kbps <= {tx_field(p, i_low_bits), 6'h00};
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_new_bw_en <= 1'b0;
    else
      o_new_bw_en <= en_word[BIT_NEW_BW_EN];
  end

  // ****************************************************************
  // Storm protection
  // ****************************************************************
  logic [THRESH_W-1:0] thresh_sel;

  always_comb
  begin
    if (|i_link_10m)
      thresh_sel = slow_word[THRESH_W-1:0];
    else
      thresh_sel = storm_word[THRESH_W-1:0];
  end

  storm_window_monitor #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_storm (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_storm_en   (storm_word[BIT_STORM_EN]),
    .i_drop_en    (storm_word[BIT_STORM_DROP]),
    .i_thresh     (thresh_sel),
    .i_bcast_pkt  (i_bcast_pkt),
    .o_storm      (o_storm_active),
    .o_drop       (o_storm_drop),
    .o_window_end (o_storm_window_end)
  );

endmodule

// ---- hdl/rate_storm_pkg.sv ----
// Shared constants and types for the rate limit and storm configuration bank
package rate_storm_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_LIMIT_ENABLE   = 8'h33;
  localparam logic [7:0] IDX_TX_LOW_P2_P5   = 8'h34;
  localparam logic [7:0] IDX_RX_MID_P0_P3   = 8'h35;
  localparam logic [7:0] IDX_MID_MIXED      = 8'h36;
  localparam logic [7:0] IDX_TX_MID_P2_P5   = 8'h37;
  localparam logic [7:0] IDX_RX_TOP_P0_P4   = 8'h38;
  localparam logic [7:0] IDX_TOP_MIXED      = 8'h39;
  localparam logic [7:0] IDX_TX_TOP_P4_P5   = 8'h3A;
  localparam logic [7:0] IDX_STORM_CTRL     = 8'h3B;
  localparam logic [7:0] IDX_STORM_SLOW     = 8'h3C;
  localparam logic [7:0] IDX_RESERVED_A     = 8'h3D;
  localparam logic [7:0] IDX_RESERVED_B     = 8'h3E;
  localparam logic [7:0] IDX_RESERVED_C     = 8'h3F;
  localparam logic [7:0] IDX_FIRST          = IDX_LIMIT_ENABLE;
  localparam logic [7:0] IDX_LAST           = IDX_RESERVED_C;
  localparam int         NUM_REGS           = 13;

  // ****************************************************************
  // Reset values and writable bits, picked per index by reset_of and mask_of
  // ****************************************************************
  localparam logic [15:0] RST_ZERO       = 16'h0000;
  localparam logic [15:0] RST_RESERVED_A = 16'h00FF;
  localparam logic [15:0] RST_RESERVED_C = 16'h7C80;
  localparam logic [15:0] MASK_ENABLE    = 16'h1FFF;
  localparam logic [15:0] MASK_ALL       = 16'hFFFF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_NEW_BW_EN   = 12;
  localparam int BIT_STORM_DROP  = 14;
  localparam int BIT_STORM_EN    = 13;
  localparam int THRESH_W        = 13;
  localparam int RATE_FIELD_W    = 11;
  localparam int RATE_PAD_W      = 6;
  localparam int RATE_KBPS_W     = RATE_FIELD_W + RATE_PAD_W;
  localparam int NUM_PORTS       = 6;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int STORM_WINDOW_MS = 50;
  localparam int CLK_KHZ         = 100000;
  localparam int STORM_WINDOW_CYC = STORM_WINDOW_MS * CLK_KHZ;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic                   en;
    logic [RATE_KBPS_W-1:0] kbps;
  } rate_limit_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0][3:0] rx_b3_0;
    logic [1:0][3:0]           tx_b3_0_p0_p1;
  } low_bits_t;

endpackage

// ---- hdl/storm_window_monitor.sv ----
// Broadcast storm detector over fixed measurement windows
`timescale 1ns/1ps
module storm_window_monitor
  import rate_storm_pkg::*;
#(
  parameter int WINDOW_CYC = STORM_WINDOW_CYC
)
(
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // Control
  input  wire logic                i_storm_en,
  input  wire logic                i_drop_en,
  input  wire logic [THRESH_W-1:0] i_thresh,
  // Events
  input  wire logic                i_bcast_pkt,
  // Status
  output logic                     o_storm,
  output logic                     o_drop,
  output logic                     o_window_end
);

  localparam int CNT_W = $clog2(WINDOW_CYC);

  logic [CNT_W-1:0]  timer_reg;
  logic [THRESH_W:0] pkt_cnt_reg;
  logic [THRESH_W:0] pkt_cnt_next;
  logic              win_end;

  generate
    if (WINDOW_CYC < 2)
    begin : g_bad_window
      $error("storm window must be at least two cycles");
    end
  endgenerate

  // ****************************************************************
  // Free-running window timer
  // ****************************************************************
  assign win_end = (timer_reg == CNT_W'(WINDOW_CYC - 1));

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      timer_reg <= '0;
    else if (win_end)
      timer_reg <= '0;
    else
      timer_reg <= timer_reg + 1'b1;
  end

  // ****************************************************************
  // Saturating packet count within the window
  // ****************************************************************
  always_comb
  begin
    pkt_cnt_next = pkt_cnt_reg;
    if (i_bcast_pkt && !(&pkt_cnt_reg))
      pkt_cnt_next = pkt_cnt_reg + 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      pkt_cnt_reg <= '0;
    else if (win_end)
      pkt_cnt_reg <= '0;
    else
      pkt_cnt_reg <= pkt_cnt_next;
  end

  // ****************************************************************
  // Storming period and drop decision
  // ****************************************************************
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_storm <= 1'b0;
      o_drop  <= 1'b0;
    end
    else if (win_end || !i_storm_en)
    begin
      o_storm <= 1'b0;
      o_drop  <= 1'b0;
    end
    else if (pkt_cnt_next > {1'b0, i_thresh})
    begin
      o_storm <= 1'b1;
      o_drop  <= i_drop_en;
    end
    else
      o_drop  <= o_storm & i_drop_en;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_window_end <= 1'b0;
    else
      o_window_end <= win_end;
  end

endmodule

// ---- testbench/port_rate_limit_storm_cfg_assertions.sv ----
// Concurrent checks on the ports of the rate limit and storm configuration bank
`timescale 1ns/1ps
module rate_storm_cfg_checker
#(
  parameter int WINDOW_CYC = 64
)
(
  // Clock, reset and requests
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        i_bcast_pkt,
  // Observed outputs
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_new_bw_en,
  input wire logic        o_storm_active,
  input wire logic        o_storm_drop,
  input wire logic        o_storm_window_end
);
  // ****************************************************************
  // Window spacing counter
  // ****************************************************************
  logic [31:0] gap_reg;
  logic        seen_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b0;
    end
    else if (o_storm_window_end)
    begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b1;
    end
    else
      gap_reg <= gap_reg + 32'h1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  AST_ACK_NEXT: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered after one cycle");
  AST_ACK_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RDATA_IDLE: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("read data not zero while waiting");
  AST_RDATA_HIGH: assert property (o_avs_readdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  AST_NEWBW_CAUSE: assert property (
    $changed(o_new_bw_en) |-> $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("new scheme enable changed without a write");
  AST_STORM_CAUSE: assert property (
    $rose(o_storm_active)
    |-> $past(i_bcast_pkt) || $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("storm raised without a broadcast frame");
  AST_STORM_WRAP: assert property (o_storm_window_end |-> !o_storm_active)
    else $error("storm still active after window wrap");
  AST_DROP_CAUSE: assert property (
    o_storm_drop |-> o_storm_active || $past(o_storm_active))
    else $error("drop active outside a storm");
  AST_WIN_GAP: assert property (
    o_storm_window_end && seen_reg |-> gap_reg == 32'(WINDOW_CYC - 1))
    else $error("window end spacing wrong");
  AST_WIN_BOUND: assert property (gap_reg <= 32'(WINDOW_CYC))
    else $error("window end missing");

  COV_STORM: cover property ($rose(o_storm_active));
  COV_DROP: cover property ($rose(o_storm_drop));
  COV_READ: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind port_rate_limit_storm_cfg rate_storm_cfg_checker #(.WINDOW_CYC(WINDOW_CYC)) chk_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_bcast_pkt(i_bcast_pkt), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_new_bw_en(o_new_bw_en),
  .o_storm_active(o_storm_active), .o_storm_drop(o_storm_drop),
  .o_storm_window_end(o_storm_window_end));

// ---- testbench/port_rate_limit_storm_cfg_bench.sv ----
// Self-checking bench for the rate limit and storm configuration bank
`timescale 1ns/1ps
module port_rate_limit_storm_cfg_bench
  import rate_storm_pkg::*;
;
  localparam int WIN     = 64;
  localparam int RXB [6] = '{0, 2, 4, 6, 7, 8};
  localparam int TXB [6] = '{1, 3, 5, 9, 10, 11};
  logic              i_ref_clk = 1'b0;
  logic              i_rst     = 1'b1;
  logic [9:0]        adr       = 10'h0;
  logic              rd        = 1'b0;
  logic              wr        = 1'b0;
  logic [31:0]       wdat      = 32'h0;
  logic [3:0]        be        = 4'h0;
  low_bits_t         lowb      = '0;
  logic [5:0]        l10       = 6'h0;
  logic              bpkt      = 1'b0;
  logic [31:0]       rdat;
  logic              wreq;
  rate_limit_t [5:0] rxl;
  rate_limit_t [5:0] txl;
  logic              nbw;
  logic              stm;
  logic              drp;
  logic              wend;
  logic [15:0]       sh [8];
  int                miscompares = 0;
  int                checked     = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  port_rate_limit_storm_cfg #(.ADDR_W(10), .WINDOW_CYC(WIN)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_low_bits(lowb),
    .i_link_10m(l10), .i_bcast_pkt(bpkt), .o_rx_limit(rxl), .o_tx_limit(txl),
    .o_new_bw_en(nbw), .o_storm_active(stm), .o_storm_drop(drp),
    .o_storm_window_end(wend));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    adr  <= {idx, 2'b00};
    rd   <= !w;
    wr   <= w;
    wdat <= {16'hA5A5, d};
    be   <= b;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      chk("bus answer", 32'h0, 32'h1);
  endtask

  task automatic wr16(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, idx, d, b, q);
  endtask

  task automatic rd16(input logic [7:0] idx, input logic [15:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0, 4'hF, q);
    chk(nm, q, {16'h0, e});
  endtask

  task automatic wait_wend();
    int k;
    k = 0;
    do
    begin
      @(posedge i_ref_clk);
      k++;
    end
    while (wend !== 1'b1 && k < 200);
    if (k >= 200)
      chk("window end", 32'h0, 32'h1);
  endtask

  function automatic logic [16:0] rxk(input int p);
    logic [3:0] m;
    logic [2:0] t;
    m = p < 4 ? sh[2][4*p +: 4] : sh[3][4*(p-4) +: 4];
    t = p < 5 ? sh[5][3*p +: 3] : sh[6][2:0];
    return {t, m, lowb.rx_b3_0[p], 6'h0};
  endfunction

  function automatic logic [16:0] txk(input int p);
    logic [3:0] l;
    logic [3:0] m;
    logic [2:0] t;
    l = p < 2 ? lowb.tx_b3_0_p0_p1[p] : sh[1][4*(p-2) +: 4];
    m = p < 2 ? sh[3][8+4*p +: 4] : sh[4][4*(p-2) +: 4];
    t = p < 4 ? sh[6][3+3*p +: 3] : sh[7][3*(p-4) +: 3];
    return {t, m, l, 6'h0};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < NUM_REGS; i++)
      rd16(IDX_FIRST + 8'(i),
           i == 10 ? RST_RESERVED_A : i == 12 ? RST_RESERVED_C : RST_ZERO, "reset");
    chk("storm after reset", 32'(stm), 32'h0);
  endtask

  task automatic t_access();
    wr16(IDX_RESERVED_A, 16'hAB12, 4'h2);
    rd16(IDX_RESERVED_A, 16'hABFF, "byte lane");
    for (int i = 0; i < NUM_REGS; i++)
    begin
      wr16(IDX_FIRST + 8'(i), 16'hFFFF, 4'h3);
      rd16(IDX_FIRST + 8'(i), i == 0 ? MASK_ENABLE : MASK_ALL, "all ones");
    end
    chk("new scheme on", 32'(nbw), 32'h1);
    wr16(8'h40, 16'h1234, 4'h3);
    rd16(8'h40, 16'h0, "unmapped");
  endtask

  task automatic t_limits();
    logic [15:0] v [8] = '{16'h0A95, 16'h9A5C, 16'h1234, 16'h5678, 16'h9ABC, 16'h4D2B,
                           16'h6E35, 16'h8017};
    lowb <= {24'h3C5A69, 8'hE1};
    for (int i = 0; i < 8; i++)
    begin
      wr16(IDX_FIRST + 8'(i), v[i], 4'h3);
      sh[i] = v[i];
    end
    repeat (2) @(posedge i_ref_clk);
    for (int p = 0; p < 6; p++)
    begin
      chk("rx kbps", 32'(rxl[p].kbps), 32'(rxk(p)));
      chk("tx kbps", 32'(txl[p].kbps), 32'(txk(p)));
      chk("rx enable", 32'(rxl[p].en), 32'(v[0][RXB[p]]));
      chk("tx enable", 32'(txl[p].en), 32'(v[0][TXB[p]]));
    end
    chk("new scheme off", 32'(nbw), 32'h0);
  endtask

  task automatic storm_case(input logic [15:0] c, input logic [15:0] s, input logic [5:0] lk,
                            input int n, input logic es, input logic ed);
    wr16(IDX_STORM_CTRL, c, 4'h3);
    wr16(IDX_STORM_SLOW, s, 4'h3);
    l10 <= lk;
    wait_wend();
    bpkt <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    bpkt <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("storm", 32'(stm), 32'(es));
    chk("drop", 32'(drp), 32'(ed));
    wait_wend();
    chk("storm after window", 32'(stm), 32'h0);
  endtask

  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_access();
    t_limits();
    storm_case(16'h6003, 16'h0005, 6'h00, 4, 1'b1, 1'b1);
    storm_case(16'h2003, 16'h0005, 6'h00, 3, 1'b0, 1'b0);
    storm_case(16'h2003, 16'h0005, 6'h04, 5, 1'b0, 1'b0);
    storm_case(16'h2003, 16'h0005, 6'h04, 6, 1'b1, 1'b0);
    storm_case(16'h0003, 16'h0005, 6'h00, 6, 1'b0, 1'b0);
    storm_case(16'h2010, 16'h0002, 6'h00, 4, 1'b0, 1'b0);
    stop_test();
  end

  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end
endmodule
